// *** design/fhc_pkg.sv ***
// Purpose: Constants for the framer HDLC controller
// Assumes: APB byte address is four times the register index
// Notes: Indices are those of framer 1
package fhc_pkg;
   localparam logic [11:0] R_RMAP = 12'h010;
   localparam logic [11:0] R_RSUP = 12'h011;
   localparam logic [11:0] R_RWM = 12'h087;
   localparam logic [11:0] R_RLAT = 12'h094;
   localparam logic [11:0] R_RMSK = 12'h0a4;
   localparam logic [11:0] R_RLIVE = 12'h0b4;
   localparam logic [11:0] R_RAVL = 12'h0b5;
   localparam logic [11:0] R_RFIFO = 12'h0b6;
   localparam logic [11:0] R_TC1 = 12'h110;
   localparam logic [11:0] R_TSUP = 12'h111;
   localparam logic [11:0] R_TMAP = 12'h113;
   localparam logic [11:0] R_TWM = 12'h187;
   localparam logic [11:0] R_TLAT = 12'h191;
   localparam logic [11:0] R_TMSK = 12'h1a1;
   localparam logic [11:0] R_TLIVE = 12'h1b1;
   localparam logic [11:0] R_TSPC = 12'h1b3;
   localparam logic [11:0] R_TFIFO = 12'h1b4;
   localparam logic [11:0] STRIDE = 12'h200;
   localparam logic [6:0] DEPTH = 7'h40;
   localparam int MODE_LSB = 5;
   localparam int MODE_MSB = 6;
   localparam int SLOT_MSB = 4;
   localparam logic [1:0] MODE_SLOT = 2'h0;
   localparam logic [1:0] MODE_SA = 2'h1;
   localparam logic [1:0] MODE_FDL = 2'h2;
   localparam logic [2:0] SA_FIRST = 3'h3;
   localparam int WM_MSB = 6;
   localparam int RL_EMPTY = 0;
   localparam int RL_HWM = 1;
   localparam int RL_OVR = 5;
   localparam int RX_HWM = 1;
   localparam int RX_END = 3;
   localparam int RX_BAD = 4;
   localparam int RX_OVR = 5;
   localparam int TL_LWM = 0;
   localparam int TL_EMPTY = 1;
   localparam int TX_LWM = 0;
   localparam int TX_UDR = 2;
   localparam int TC_ABORT = 0;
   localparam int TC_EOM = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] RWM_RST = 8'h30;
   localparam logic [7:0] TWM_RST = 8'h10;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_GOOD = 16'hf0b8;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [7:0] ABORT_BYTE = 8'hff;
   typedef enum logic [2:0] {K_FLAG, K_DATA, K_CRC1, K_CRC2, K_ABORT}
      fhc_kind_t;
endpackage

// *** design/fhc_hdlc_ctrl.sv ***
// Purpose: HDLC controller of one framer, APB register side
// Assumes: Line bit strobes come from framer logic on mclk
// Notes: APB answers in the second access cycle
`timescale 1ns/1ps
// Notes on behaviour
// - Channel in slot, Sa4-Sa8 or FDL
// - Separate 64-byte transmit and receive FIFOs
// - Per-bit selection, unselected bits suppressed
// - Flags and aborts sent and recognised
// - FCS appended on transmit, checked on receive
// - Zero stuffing, destuffing, byte alignment
// - FIFOs hold a whole report message
// - Watermark levels in FIFO control registers
// - Rx high watermark live flag, bit 1
// - Tx low watermark live flag
// - Masked watermark event drives interrupt
// - Overrun drops packet, empties FIFO, flags
// - Low 7 bits give readable byte count
// - Count covers start, middle, end or whole
// - MSB set while packet not terminated
// - Latched bit cleared by writing one
// - Live bits follow state, ignore writes
// - Each latched event individually maskable
// - Unmasked event pulls interrupt low
// - Reading event bit releases interrupt
// - Tx space count, stable during read
// - Framer n at base plus (n-1)*200h
module fhc_hdlc_ctrl #(
   parameter int FRAMER_NUM = 1
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxBitStb,
   input wire logic rxBit,
   input wire logic [4:0] rxSlot,
   input wire logic [2:0] rxBitIdx,
   input wire logic rxSaFrame,
   input wire logic rxFdlBit,
   input wire logic txBitStb,
   input wire logic [4:0] txSlot,
   input wire logic [2:0] txBitIdx,
   input wire logic txSaFrame,
   input wire logic txFdlBit,
   output logic txLinkData,
   output logic txLinkInsert,
   output logic interruptOutN
);
   if (FRAMER_NUM < 1 || FRAMER_NUM > 8) begin : g_chk
      $error("FRAMER_NUM must be 1 to 8");
   end

   localparam logic [11:0] BASE =
      12'(12'(FRAMER_NUM - 1) * fhc_pkg::STRIDE);

   function automatic logic mapHit(input logic [7:0] mp,
      input logic [7:0] sp, input logic [4:0] ts, input logic [2:0] bi,
      input logic sa, input logic fdl);
      logic [1:0] m;
      logic h;
      m = mp[fhc_pkg::MODE_MSB:fhc_pkg::MODE_LSB];
      h = 1'b0;
      if (m == fhc_pkg::MODE_SLOT) begin
         h = ts == mp[fhc_pkg::SLOT_MSB:0] && !sp[bi];
      end else if (m == fhc_pkg::MODE_SA) begin
         h = ts == 5'h0 && sa && bi >= fhc_pkg::SA_FIRST &&
            !sp[bi - fhc_pkg::SA_FIRST];
      end else if (m == fhc_pkg::MODE_FDL) begin
         h = fdl;
      end
      return h;
   endfunction

   function automatic logic [15:0] crcF(input logic [15:0] c,
      input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ fhc_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [7:0] availF(input logic [63:0] eop,
      input logic [5:0] rp, input logic [6:0] cnt);
      logic [7:0] r;
      logic found;
      logic [5:0] p;
      r = {cnt != 7'h0, cnt};
      found = 1'b0;
      for (int i = 0; i < 64; i++) begin
         p = rp + 6'(i);
         if (!found && 7'(i) < cnt && eop[p]) begin
            found = 1'b1;
            r = {1'b0, 7'(i + 1)};
         end
      end
      return r;
   endfunction

   // Register state
   logic [7:0] rMap_q, rSup_q, rWm_q, rMsk_q, rLat_q, rPend_q;
   logic [7:0] tMap_q, tSup_q, tWm_q, tMsk_q, tLat_q, tPend_q;
   logic tAbortReq_q, tEomNext_q, rxHwmOld_q, txLwmOld_q;

   // APB decode
   logic [11:0] idx;
   logic ok, acc, wrA, rdA, capt, mapped;
   logic hRMap, hRSup, hRWm, hRLat, hRMsk, hRLive, hRAvl, hRFifo;
   logic hTC1, hTSup, hTMap, hTWm, hTLat, hTMsk, hTLive, hTSpc, hTFifo;
   logic [7:0] rdMux, rxLive, txLive, rxEvt, txEvt;
   assign idx = paddr[13:2] - BASE;
   assign ok = paddr[1:0] == 2'h0;
   assign acc = psel & penable & pready;
   assign wrA = acc & pwrite;
   assign rdA = acc & !pwrite;
   assign capt = psel & penable & !pready;
   assign hRMap = ok && idx == fhc_pkg::R_RMAP;
   assign hRSup = ok && idx == fhc_pkg::R_RSUP;
   assign hRWm = ok && idx == fhc_pkg::R_RWM;
   assign hRLat = ok && idx == fhc_pkg::R_RLAT;
   assign hRMsk = ok && idx == fhc_pkg::R_RMSK;
   assign hRLive = ok && idx == fhc_pkg::R_RLIVE;
   assign hRAvl = ok && idx == fhc_pkg::R_RAVL;
   assign hRFifo = ok && idx == fhc_pkg::R_RFIFO;
   assign hTC1 = ok && idx == fhc_pkg::R_TC1;
   assign hTSup = ok && idx == fhc_pkg::R_TSUP;
   assign hTMap = ok && idx == fhc_pkg::R_TMAP;
   assign hTWm = ok && idx == fhc_pkg::R_TWM;
   assign hTLat = ok && idx == fhc_pkg::R_TLAT;
   assign hTMsk = ok && idx == fhc_pkg::R_TMSK;
   assign hTLive = ok && idx == fhc_pkg::R_TLIVE;
   assign hTSpc = ok && idx == fhc_pkg::R_TSPC;
   assign hTFifo = ok && idx == fhc_pkg::R_TFIFO;
   assign mapped = hRMap | hRSup | hRWm | hRLat | hRMsk | hRLive |
      hRAvl | hRFifo | hTC1 | hTSup | hTMap | hTWm | hTLat | hTMsk |
      hTLive | hTSpc | hTFifo;

   // Receive FIFO
   logic [7:0] rxMem [64];
   logic [63:0] rxEop_q, rxBad_q;
   logic [5:0] rxWp_q, rxRp_q;
   logic [6:0] rxCnt_q;
   logic rxPush, rxPop, rxWr, ovr, endEv, endBad, abortEv;
   logic [7:0] rxAvail;
   assign rxAvail = availF(rxEop_q, rxRp_q, rxCnt_q);
   assign rxPop = rdA && hRFifo && rxCnt_q != 7'h0;
   assign ovr = rxPush && rxCnt_q == fhc_pkg::DEPTH && !rxPop;
   assign rxWr = rxPush && !ovr;

   // Receive deframer
   logic [2:0] rOnes_q, rBc_q;
   logic [7:0] rSh_q, rH0_q, rH1_q, newByte;
   logic [1:0] rHc_q;
   logic [15:0] rCrc_q;
   logic rInF_q, rAny_q, rDisc_q, rxHit, stuffed, flagD, abortD;
   logic dataBit, byteDone;
   assign rxHit = rxBitStb &&
      mapHit(rMap_q, rSup_q, rxSlot, rxBitIdx, rxSaFrame, rxFdlBit);
   assign stuffed = !rxBit && rOnes_q == 3'h5;
   assign flagD = !rxBit && rOnes_q == 3'h6;
   assign abortD = rxBit && rOnes_q == 3'h6;
   assign dataBit = rxHit && rInF_q && !stuffed && !flagD && !abortD;
   assign byteDone = dataBit && rBc_q == 3'h7;
   assign newByte = {rxBit, rSh_q[7:1]};
   assign rxPush = byteDone && rHc_q == 2'h2 && !rDisc_q;
   assign endEv = rxHit && flagD && rInF_q && rAny_q && !rDisc_q;
   assign endBad = rBc_q != 3'h7 || rCrc_q != fhc_pkg::CRC_GOOD;
   assign abortEv = rxHit && abortD && rInF_q && rAny_q && !rDisc_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rOnes_q <= 3'h0;
         rBc_q <= 3'h0;
         rSh_q <= 8'h00;
         rH0_q <= 8'h00;
         rH1_q <= 8'h00;
         rHc_q <= 2'h0;
         rCrc_q <= fhc_pkg::CRC_INIT;
         rInF_q <= 1'b0;
         rAny_q <= 1'b0;
         rDisc_q <= 1'b0;
      end else begin
         if (rxHit) begin
            rOnes_q <= !rxBit ? 3'h0 : (rOnes_q == 3'h7 ? 3'h7 :
               rOnes_q + 3'h1);
            if (flagD) begin
               rInF_q <= 1'b1;
               rBc_q <= 3'h0;
               rHc_q <= 2'h0;
               rAny_q <= 1'b0;
               rCrc_q <= fhc_pkg::CRC_INIT;
               rDisc_q <= 1'b0;
            end else if (abortD) begin
               rInF_q <= 1'b0;
            end else if (dataBit) begin
               rSh_q <= newByte;
               rBc_q <= rBc_q + 3'h1;
               if (byteDone) begin
                  rCrc_q <= crcF(rCrc_q, newByte);
                  rH1_q <= newByte;
                  rH0_q <= rH1_q;
                  rHc_q <= (rHc_q == 2'h2) ? 2'h2 : rHc_q + 2'h1;
                  rAny_q <= rAny_q | rxWr;
               end
            end
         end
         if (ovr) begin
            rDisc_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rxWr) begin
         rxMem[rxWp_q] <= rH0_q;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rxWp_q <= 6'h0;
         rxRp_q <= 6'h0;
         rxCnt_q <= 7'h0;
         rxEop_q <= '0;
         rxBad_q <= '0;
      end else if (ovr) begin
         rxWp_q <= 6'h0;
         rxRp_q <= 6'h0;
         rxCnt_q <= 7'h0;
         rxEop_q <= '0;
      end else begin
         rxWp_q <= rxWp_q + 6'(rxWr);
         rxRp_q <= rxRp_q + 6'(rxPop);
         rxCnt_q <= rxCnt_q + 7'(rxWr) - 7'(rxPop);
         if (rxWr) begin
            rxEop_q[rxWp_q] <= 1'b0;
         end
         if (endEv || abortEv) begin
            rxEop_q[rxWp_q - 6'h1] <= 1'b1;
            rxBad_q[rxWp_q - 6'h1] <= abortEv || endBad;
         end
      end
   end

   // Transmit FIFO and framer
   logic [8:0] txMem [64];
   logic [5:0] txWp_q, txRp_q;
   logic [6:0] txCnt_q;
   logic txPush, txPop, txHit, stuffT, lastBit, outBit, udr;
   fhc_pkg::fhc_kind_t tKind_q, nKind;
   logic [7:0] tSh_q, nSh;
   logic [2:0] tBc_q, tOnes_q;
   logic [15:0] tCrc_q, nCrc;
   logic tEom_q, nEom, popSel, abTake;
   assign txPush = wrA && hTFifo && txCnt_q != fhc_pkg::DEPTH;
   assign txHit = txBitStb &&
      mapHit(tMap_q, tSup_q, txSlot, txBitIdx, txSaFrame, txFdlBit);
   assign stuffT = tKind_q != fhc_pkg::K_FLAG &&
      tKind_q != fhc_pkg::K_ABORT && tOnes_q == 3'h5;
   assign outBit = stuffT ? 1'b0 : tSh_q[0];
   assign lastBit = txHit && !stuffT && tBc_q == 3'h7;
   assign txPop = lastBit && popSel;

   always_comb begin
      nKind = fhc_pkg::K_FLAG;
      nSh = fhc_pkg::FLAG_BYTE;
      nCrc = tCrc_q;
      nEom = 1'b0;
      popSel = 1'b0;
      udr = 1'b0;
      abTake = 1'b0;
      if (tAbortReq_q && tKind_q != fhc_pkg::K_ABORT) begin
         abTake = 1'b1;
      end else if (tKind_q == fhc_pkg::K_DATA && tEom_q) begin
         nKind = fhc_pkg::K_CRC1;
         nSh = ~tCrc_q[7:0];
      end else if (tKind_q == fhc_pkg::K_CRC1) begin
         nKind = fhc_pkg::K_CRC2;
         nSh = ~tCrc_q[15:8];
      end else if (tKind_q == fhc_pkg::K_DATA ||
         tKind_q == fhc_pkg::K_FLAG) begin
         popSel = txCnt_q != 7'h0;
         udr = !popSel && tKind_q == fhc_pkg::K_DATA;
      end
      if (popSel) begin
         nKind = fhc_pkg::K_DATA;
         nSh = txMem[txRp_q][7:0];
         nEom = txMem[txRp_q][8];
         nCrc = crcF(tKind_q == fhc_pkg::K_DATA ? tCrc_q :
            fhc_pkg::CRC_INIT, txMem[txRp_q][7:0]);
      end
      if (abTake || udr) begin
         nKind = fhc_pkg::K_ABORT;
         nSh = fhc_pkg::ABORT_BYTE;
      end
   end

   always_ff @(posedge mclk) begin
      if (txPush) begin
         txMem[txWp_q] <= {tEomNext_q, pwdata[7:0]};
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txWp_q <= 6'h0;
         txRp_q <= 6'h0;
         txCnt_q <= 7'h0;
         tKind_q <= fhc_pkg::K_FLAG;
         tSh_q <= fhc_pkg::FLAG_BYTE;
         tBc_q <= 3'h0;
         tOnes_q <= 3'h0;
         tCrc_q <= fhc_pkg::CRC_INIT;
         tEom_q <= 1'b0;
         txLinkData <= 1'b0;
         txLinkInsert <= 1'b0;
      end else begin
         txWp_q <= txWp_q + 6'(txPush);
         txRp_q <= txRp_q + 6'(txPop);
         txCnt_q <= txCnt_q + 7'(txPush) - 7'(txPop);
         txLinkInsert <= txHit;
         if (txHit) begin
            txLinkData <= outBit;
            tOnes_q <= (stuffT || !outBit || tKind_q == fhc_pkg::K_FLAG ||
               tKind_q == fhc_pkg::K_ABORT) ? 3'h0 : tOnes_q + 3'h1;
            if (lastBit) begin
               tKind_q <= nKind;
               tSh_q <= nSh;
               tBc_q <= 3'h0;
               tEom_q <= nEom;
               tCrc_q <= nCrc;
            end else if (!stuffT) begin
               tSh_q <= tSh_q >> 1;
               tBc_q <= tBc_q + 3'h1;
            end
         end
      end
   end

   // Live status, events, latched status and interrupt
   logic rxHwm, txLwm, popEop;
   assign rxHwm = rxCnt_q > rWm_q[fhc_pkg::WM_MSB:0];
   assign txLwm = txCnt_q < tWm_q[fhc_pkg::WM_MSB:0];
   assign popEop = rxPop && rxEop_q[rxRp_q];
   always_comb begin
      rxLive = 8'h00;
      rxLive[fhc_pkg::RL_EMPTY] = rxCnt_q == 7'h0;
      rxLive[fhc_pkg::RL_HWM] = rxHwm;
      rxLive[fhc_pkg::RL_OVR] = rDisc_q;
      txLive = 8'h00;
      txLive[fhc_pkg::TL_LWM] = txLwm;
      txLive[fhc_pkg::TL_EMPTY] = txCnt_q == 7'h0;
      rxEvt = 8'h00;
      rxEvt[fhc_pkg::RX_HWM] = rxHwm && !rxHwmOld_q;
      rxEvt[fhc_pkg::RX_END] = popEop && !rxBad_q[rxRp_q];
      rxEvt[fhc_pkg::RX_BAD] = popEop && rxBad_q[rxRp_q];
      rxEvt[fhc_pkg::RX_OVR] = ovr;
      txEvt = 8'h00;
      txEvt[fhc_pkg::TX_LWM] = txLwm && !txLwmOld_q;
      txEvt[fhc_pkg::TX_UDR] = txPop == 1'b0 && lastBit && udr;
   end

   assign rdMux = hRMap ? rMap_q : hRSup ? rSup_q : hRWm ? rWm_q :
      hRLat ? rLat_q : hRMsk ? rMsk_q : hRLive ? rxLive :
      hRAvl ? rxAvail : hRFifo ? rxMem[rxRp_q] : hTC1 ?
      {6'h0, tEomNext_q, tAbortReq_q} : hTSup ? tSup_q :
      hTMap ? tMap_q : hTWm ? tWm_q : hTLat ? tLat_q :
      hTMsk ? tMsk_q : hTLive ? txLive :
      hTSpc ? {1'b0, fhc_pkg::DEPTH - txCnt_q} : 8'h00;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= capt;
         if (capt) begin
            prdata <= {24'h0, rdMux};
            pslverr <= !mapped;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rMap_q <= fhc_pkg::CTRL_RST;
         rSup_q <= fhc_pkg::CTRL_RST;
         rWm_q <= fhc_pkg::RWM_RST;
         rMsk_q <= fhc_pkg::CTRL_RST;
         tMap_q <= fhc_pkg::CTRL_RST;
         tSup_q <= fhc_pkg::CTRL_RST;
         tWm_q <= fhc_pkg::TWM_RST;
         tMsk_q <= fhc_pkg::CTRL_RST;
         tAbortReq_q <= 1'b0;
         tEomNext_q <= 1'b0;
      end else begin
         if (wrA && hRMap) rMap_q <= pwdata[7:0];
         if (wrA && hRSup) rSup_q <= pwdata[7:0];
         if (wrA && hRWm) rWm_q <= pwdata[7:0];
         if (wrA && hRMsk) rMsk_q <= pwdata[7:0];
         if (wrA && hTMap) tMap_q <= pwdata[7:0];
         if (wrA && hTSup) tSup_q <= pwdata[7:0];
         if (wrA && hTWm) tWm_q <= pwdata[7:0];
         if (wrA && hTMsk) tMsk_q <= pwdata[7:0];
         tAbortReq_q <= (wrA && hTC1 && pwdata[fhc_pkg::TC_ABORT]) ||
            (tAbortReq_q && !(lastBit && abTake));
         tEomNext_q <= (wrA && hTC1 && pwdata[fhc_pkg::TC_EOM]) ||
            (tEomNext_q && !txPush);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rLat_q <= 8'h00;
         tLat_q <= 8'h00;
         rPend_q <= 8'h00;
         tPend_q <= 8'h00;
         rxHwmOld_q <= 1'b0;
         txLwmOld_q <= 1'b1;
         interruptOutN <= 1'b1;
      end else begin
         rxHwmOld_q <= rxHwm;
         txLwmOld_q <= txLwm;
         rLat_q <= rxEvt | (rLat_q & ~(wrA && hRLat ? pwdata[7:0] :
            8'h00));
         tLat_q <= txEvt | (tLat_q & ~(wrA && hTLat ? pwdata[7:0] :
            8'h00));
         rPend_q <= rxEvt | (rPend_q & ~(rdA && hRLat ? rLat_q :
            8'h00));
         tPend_q <= txEvt | (tPend_q & ~(rdA && hTLat ? tLat_q :
            8'h00));
         interruptOutN <= ~|((rPend_q & rMsk_q) |
            (tPend_q & tMsk_q));
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);

   property p_rx_hwm;
      capt && !pwrite && hRLive |=>
         prdata[fhc_pkg::RL_HWM] == $past(rxCnt_q > rWm_q[6:0]);
   endproperty
   a_rx_hwm: assert property (p_rx_hwm) else $error("rx hwm bit");

   property p_tx_lwm;
      capt && !pwrite && hTLive |=>
         prdata[fhc_pkg::TL_LWM] == $past(txCnt_q < tWm_q[6:0]);
   endproperty
   a_tx_lwm: assert property (p_tx_lwm) else $error("tx lwm bit");

   property p_ovr;
      ovr |=> rxCnt_q == 7'h0 && rLat_q[fhc_pkg::RX_OVR] && rDisc_q;
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun handling");

   property p_w1c;
      wrA && hRLat && pwdata[fhc_pkg::RX_END] &&
         !rxEvt[fhc_pkg::RX_END] |=> !rLat_q[fhc_pkg::RX_END];
   endproperty
   a_w1c: assert property (p_w1c) else $error("latched clear");

   property p_int_low;
      rxEvt[fhc_pkg::RX_OVR] && rMsk_q[fhc_pkg::RX_OVR] |->
         ##2 !interruptOutN;
   endproperty
   a_int_low: assert property (p_int_low) else $error("int low");

   property p_int_rel;
      rdA && hRLat && (rPend_q & ~rLat_q) == 8'h00 &&
         rxEvt == 8'h00 |=> rPend_q == 8'h00;
   endproperty
   a_int_rel: assert property (p_int_rel) else $error("int rel");

   property p_space;
      capt && !pwrite && hTSpc |=>
         prdata[6:0] == 7'(fhc_pkg::DEPTH - $past(txCnt_q));
   endproperty
   a_space: assert property (p_space) else $error("tx space");

   property p_stuff;
      txHit && stuffT |=> txLinkInsert && !txLinkData;
   endproperty
   a_stuff: assert property (p_stuff) else $error("stuff bit");

   property p_empty_avail;
      capt && !pwrite && hRAvl && rxCnt_q == 7'h0 |=> prdata == 32'h0;
   endproperty
   a_empty_avail: assert property (p_empty_avail)
      else $error("avail empty");
endmodule

// *** verification/fhc_line_model.sv ***
// Purpose: Framer line model, tx opportunities looped to rx
// Assumes: Four-slot short frame, one bit every 2 cycles
// Notes: Idle rx data toggles so stale values never match
`timescale 1ns/1ps
module fhc_line_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic txLinkData,
   input wire logic txLinkInsert,
   output logic txBitStb,
   output logic [4:0] txSlot,
   output logic [2:0] txBitIdx,
   output logic rxBitStb,
   output logic rxBit,
   output logic [4:0] rxSlot,
   output logic [2:0] rxBitIdx
);
   logic ph;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ph <= 1'b0;
         txBitStb <= 1'b0;
         txSlot <= 5'h00;
         txBitIdx <= 3'h0;
         rxBitStb <= 1'b0;
         rxBit <= 1'b0;
         rxSlot <= 5'h00;
         rxBitIdx <= 3'h0;
      end else begin
         ph <= ~ph;
         txBitStb <= ~ph;
         if (txBitStb) begin
            txBitIdx <= txBitIdx + 3'h1;
            rxSlot <= txSlot;
            rxBitIdx <= txBitIdx;
            if (txBitIdx == 3'h7) begin
               txSlot <= (txSlot == 5'h03) ? 5'h00 : txSlot + 5'h01;
            end
         end
         rxBitStb <= txLinkInsert;
         rxBit <= txLinkInsert ? txLinkData : ~rxBit;
      end
   end
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench of the HDLC controller
// Assumes: Instance is framer 2, tx looped back to rx
// Notes: Registers reached over APB only
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] OFS = fhc_pkg::STRIDE;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic txBitStb, txLinkData, txLinkInsert, interruptOutN, rxBitStb, rxBit;
   logic [4:0] txSlot, rxSlot;
   logic [2:0] txBitIdx, rxBitIdx;
   int badCount, checkCount;
   always #5 mclk = ~mclk;
   fhc_hdlc_ctrl #(.FRAMER_NUM(2)) fhc_hdlc_ctrl_i (.mclk(mclk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxBitStb(rxBitStb), .rxBit(rxBit),
      .rxSlot(rxSlot), .rxBitIdx(rxBitIdx), .rxSaFrame(1'b0),
      .rxFdlBit(1'b0), .txBitStb(txBitStb), .txSlot(txSlot),
      .txBitIdx(txBitIdx), .txSaFrame(1'b0), .txFdlBit(1'b0),
      .txLinkData(txLinkData), .txLinkInsert(txLinkInsert),
      .interruptOutN(interruptOutN));
   fhc_line_model fhc_line_model_i (.mclk(mclk), .resetn(resetn),
      .txLinkData(txLinkData), .txLinkInsert(txLinkInsert),
      .txBitStb(txBitStb), .txSlot(txSlot), .txBitIdx(txBitIdx),
      .rxBitStb(rxBitStb), .rxBit(rxBit), .rxSlot(rxSlot),
      .rxBitIdx(rxBitIdx));
   task automatic endSim;
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checkCount++;
      if (g !== e) begin
         badCount++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx,
      input logic [7:0] wd, output logic [31:0] rd, output logic err);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         badCount++;
         endSim();
      end
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx + OFS, d, r, e);
      chk("write error", 32'h0, {31'h0, e});
   endtask
   task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
      logic [31:0] r;
      logic er;
      apb(1'b0, idx + OFS, 8'h00, r, er);
      chk("read", {24'h000000, e}, {er, r[30:0]});
   endtask
   task automatic tReset;
      rdc(fhc_pkg::R_RWM, 8'h30);
      rdc(fhc_pkg::R_TWM, 8'h10);
      rdc(fhc_pkg::R_RAVL, 8'h00);
      rdc(fhc_pkg::R_TSPC, {1'b0, fhc_pkg::DEPTH});
      rdc(fhc_pkg::R_RLAT, 8'h00);
      rdc(fhc_pkg::R_TLAT, 8'h00);
      rdc(fhc_pkg::R_TLIVE, 8'h03);
      chk("irq", 32'h1, {31'h0, interruptOutN});
   endtask
   task automatic tBus;
      logic [31:0] r;
      logic e;
      apb(1'b0, fhc_pkg::R_RMAP, 8'h00, r, e);
      chk("slverr", 32'h1, {31'h0, e});
      wr(fhc_pkg::R_RLIVE, 8'hff);
      rdc(fhc_pkg::R_RLIVE, 8'h01);
   endtask
   task automatic tLoop;
      logic [31:0] r;
      logic e;
      int n;
      logic part;
      wr(fhc_pkg::R_RMAP, 8'h03);
      wr(fhc_pkg::R_TMAP, 8'h03);
      wr(fhc_pkg::R_RWM, 8'h02);
      wr(fhc_pkg::R_RMSK, 8'h08);
      rdc(fhc_pkg::R_TMAP, 8'h03);
      wr(fhc_pkg::R_TFIFO, 8'h7e);
      wr(fhc_pkg::R_TFIFO, 8'hff);
      wr(fhc_pkg::R_TC1, 8'h02);
      wr(fhc_pkg::R_TFIFO, 8'h3c);
      n = 0;
      part = 1'b0;
      r = 32'h0;
      while (r !== 32'h3 && n < 800) begin
         apb(1'b0, fhc_pkg::R_RAVL + OFS, 8'h00, r, e);
         if (r[7] === 1'b1) part = 1'b1;
         n++;
      end
      chk("partial flag", 32'h1, {31'h0, part});
      chk("avail", 32'h3, r);
      if (r !== 32'h3) endSim();
      rdc(fhc_pkg::R_RLIVE, 8'h02);
      rdc(fhc_pkg::R_RFIFO, 8'h7e);
      rdc(fhc_pkg::R_RFIFO, 8'hff);
      rdc(fhc_pkg::R_RFIFO, 8'h3c);
      repeat (2) @(posedge mclk);
      chk("irq low", 32'h0, {31'h0, interruptOutN});
      rdc(fhc_pkg::R_RLAT, 8'h0a);
      repeat (2) @(posedge mclk);
      chk("irq high", 32'h1, {31'h0, interruptOutN});
      wr(fhc_pkg::R_RLAT, 8'h00);
      rdc(fhc_pkg::R_RLAT, 8'h0a);
      wr(fhc_pkg::R_RLAT, 8'h08);
      rdc(fhc_pkg::R_RLAT, 8'h02);
      rdc(fhc_pkg::R_RLIVE, 8'h01);
      rdc(fhc_pkg::R_RAVL, 8'h00);
   endtask
   task automatic tFill;
      wr(fhc_pkg::R_TMAP, 8'h60);
      for (int i = 0; i < 65; i++) begin
         wr(fhc_pkg::R_TFIFO, i[7:0]);
         if (i == 14) rdc(fhc_pkg::R_TLIVE, 8'h01);
         if (i == 15) rdc(fhc_pkg::R_TSPC, 8'h30);
         if (i == 15) rdc(fhc_pkg::R_TLIVE, 8'h00);
      end
      rdc(fhc_pkg::R_TSPC, 8'h00);
   endtask
   task automatic tOvr;
      logic [31:0] r;
      logic e;
      int n;
      wr(fhc_pkg::R_TMSK, 8'h01);
      wr(fhc_pkg::R_TMAP, 8'h03);
      n = 0;
      r = 32'h0;
      while (r !== 32'h40 && n < 2000) begin
         apb(1'b0, fhc_pkg::R_TSPC + OFS, 8'h00, r, e);
         n++;
      end
      chk("drained", 32'h40, r);
      if (r !== 32'h40) endSim();
      chk("irq wm", 32'h0, {31'h0, interruptOutN});
      repeat (200) @(posedge mclk);
      rdc(fhc_pkg::R_TLAT, 8'h05);
      repeat (2) @(posedge mclk);
      chk("irq wm rel", 32'h1, {31'h0, interruptOutN});
      wr(fhc_pkg::R_RMSK, 8'h20);
      wr(fhc_pkg::R_TFIFO, 8'h11);
      wr(fhc_pkg::R_TFIFO, 8'h22);
      wr(fhc_pkg::R_TC1, 8'h02);
      wr(fhc_pkg::R_TFIFO, 8'h33);
      n = 0;
      r = 32'h0;
      while (r[5] !== 1'b1 && n < 400) begin
         apb(1'b0, fhc_pkg::R_RLIVE + OFS, 8'h00, r, e);
         n++;
      end
      chk("overrun live", 32'h21, r);
      if (r !== 32'h21) endSim();
      chk("irq ovr", 32'h0, {31'h0, interruptOutN});
      rdc(fhc_pkg::R_RAVL, 8'h00);
      rdc(fhc_pkg::R_RLAT, 8'h22);
   endtask
   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 14'h0000;
      pwdata = 32'h0;
      badCount = 0;
      checkCount = 0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      tReset();
      tBus();
      tLoop();
      tFill();
      tOvr();
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      tReset();
      endSim();
   end
endmodule
